// ### bench/channel_model.sv
module channel_model #(
  parameter int SEC_CYC = 200
) (
  input  wire logic          clk,
  input  wire logic          srst,
  output logic [5:0]         tod_sec,
  output profile_pkg::value_t trig_value [profile_pkg::NUM_GEN],
  output profile_pkg::value_t loop_value [profile_pkg::NUM_GEN]
);
  timeunit 1ns;
  timeprecision 1ps;
  import profile_pkg::*;
  int cnt = 0;
  initial
  begin
    tod_sec = 6'h00;
    trig_value = '{default: 32'h0000_0000};
    loop_value = '{default: 32'h0000_0000};
  end
  // Seconds run on a short count so that a whole minute fits into the run.
  always @(negedge clk)
    if (srst)
    begin
      cnt <= 0;
      tod_sec <= 6'h00;
    end
    else if (cnt == SEC_CYC - 1)
    begin
      cnt <= 0;
      tod_sec <= (tod_sec == 6'h3B) ? 6'h00 : tod_sec + 6'h01;
    end
    else
      cnt <= cnt + 1;
  task automatic set_trig(input int g, input value_t v);
    @(negedge clk);
    trig_value[g] = v;
  endtask
  task automatic set_loop(input int g, input value_t v);
    loop_value[g] = v;
  endtask
endmodule // channel_model

// ### bench/profile_bank_properties.sv
module profile_bank_checker (
  input wire logic                    clk,
  input wire logic                    srst,
  input wire profile_pkg::trig_mode_t trig_mode [profile_pkg::NUM_GEN],
  input wire profile_pkg::sect_idx_t  sect_count [profile_pkg::NUM_GEN],
  input wire profile_pkg::value_t     idle_value [profile_pkg::NUM_GEN],
  input wire profile_pkg::value_t     trig_value [profile_pkg::NUM_GEN],
  input wire profile_pkg::value_t     out_value [profile_pkg::NUM_GEN],
  input wire logic                    running [profile_pkg::NUM_GEN]
);
  timeunit 1ns;
  timeprecision 1ps;
  import profile_pkg::*;
  default clocking @(posedge clk); endclocking
  default disable iff (srst);
  // Generator 0 stands for all eight, since they share one body.
  property p_idle_hold;
    !running[0] ##1 !running[0] |-> out_value[0] == $past(idle_value[0]);
  endproperty
  a_idle_hold: assert property (p_idle_hold) else $error("idle value missing");
  property p_done_idle;
    $fell(running[0]) |-> ##1 out_value[0] == idle_value[0];
  endproperty
  a_done_idle: assert property (p_done_idle) else $error("no idle after run");
  property p_off;
    trig_mode[0] == TRIG_OFF && !running[0] |=> !running[0];
  endproperty
  a_off: assert property (p_off) else $error("start while disabled");
  property p_no_sect;
    sect_count[0] == 7'h00 && !running[0] |=> !running[0];
  endproperty
  a_no_sect: assert property (p_no_sect) else $error("start with empty list");
  property p_gate_start;
    trig_mode[0] == TRIG_GATE && !running[0] && sect_count[0] != 7'h00 && trig_value[0] > 0
      && $past(trig_value[0]) <= 0 |=> running[0];
  endproperty
  a_gate_start: assert property (p_gate_start) else $error("gate did not start");
  property p_gate_stop;
    trig_mode[0] == TRIG_GATE && running[0] && trig_value[0] <= 0 |=> !running[0];
  endproperty
  a_gate_stop: assert property (p_gate_stop) else $error("gate did not stop");
  property p_once_start;
    trig_mode[0] == TRIG_ONCE && !running[0] && sect_count[0] != 7'h00 && trig_value[0] > 0
      && $past(trig_value[0]) <= 0 |=> running[0];
  endproperty
  a_once_start: assert property (p_once_start) else $error("edge did not start");
  property p_retrig;
    trig_mode[0] == TRIG_RETRIG && sect_count[0] != 7'h00 && trig_value[0] > 0
      && $past(trig_value[0]) <= 0 |=> running[0];
  endproperty
  a_retrig: assert property (p_retrig) else $error("edge did not restart");
endmodule // profile_bank_checker

// ### bench/tb.sv
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  import profile_pkg::*;
  localparam int TC = 4;
  typedef struct {loop_mode_t lm; logic [31:0] lc; value_t lv; int ticks;} row_t;
  logic        clk = 1'b0;
  logic        srst = 1'b1;
  logic        cfg_we = 1'b0;
  logic [2:0]  cfg_gen = 3'h0;
  sect_idx_t   cfg_sect = 7'h00;
  section_t    cfg_section = SECT_RESET;
  trig_mode_t  trig_mode [NUM_GEN];
  loop_mode_t  loop_mode [NUM_GEN];
  logic [31:0] loop_count [NUM_GEN];
  sect_idx_t   loop_restart_section [NUM_GEN], sect_count [NUM_GEN];
  value_t      idle_value [NUM_GEN], trig_value [NUM_GEN], loop_value [NUM_GEN];
  value_t      out_value [NUM_GEN];
  logic        running [NUM_GEN];
  logic [12:0] month_mask [NUM_GEN];
  logic [31:0] day_mask [NUM_GEN];
  logic [6:0]  wday_mask [NUM_GEN];
  logic [23:0] hour_mask [NUM_GEN];
  logic [59:0] min_mask [NUM_GEN], sec_mask [NUM_GEN];
  logic [3:0]  tod_month = 4'h6;
  logic [4:0]  tod_day = 5'h04, tod_hour = 5'h0E;
  logic [2:0]  tod_wday = 3'h4;
  logic [5:0]  tod_min = 6'h2A, tod_sec;
  int          mismatches = 0, total_checks = 0, c;
  section_t    secs [3] = '{'{16'h0001, UNIT_SEC, SHAPE_CONST, 32'h0000_0007},
    '{16'h0001, UNIT_SEC, SHAPE_SLOPE, 32'h0000_006B},
    '{16'h0001, UNIT_SEC, SHAPE_CONST, 32'h0000_002F}};
  row_t        rows [5] = '{'{LOOP_OFF, 32'h0000_0000, 32'h0000_0000, 300},
    '{LOOP_COUNTED, 32'h0000_0002, 32'h0000_0000, 500},
    '{LOOP_CHANNEL, 32'h0000_0000, 32'h0000_0003, 700},
    '{LOOP_CHANNEL, 32'h0000_0000, 32'h0000_0000, 300},
    '{LOOP_INFINITE, 32'h0000_0000, 32'h0000_0000, 800}};
  always #2.5 clk = ~clk;
  channel_model ch_u (.clk, .srst, .tod_sec, .trig_value, .loop_value);
  profile_bank #(.TICK_CYCLES(TC)) dut_u (.clk, .srst, .cfg_we, .cfg_gen, .cfg_sect,
    .cfg_section, .trig_mode, .loop_mode, .loop_count, .loop_restart_section, .sect_count,
    .idle_value, .trig_value, .loop_value, .month_mask, .day_mask, .wday_mask, .hour_mask,
    .min_mask, .sec_mask, .tod_month, .tod_day, .tod_wday, .tod_hour, .tod_min, .tod_sec,
    .out_value, .running);
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    total_checks++;
    if (got !== exp)
    begin
      mismatches++;
      $display("CHECK FAILED %s expected %0d seen %0d", what, exp, got);
    end
  endtask
  // Tick phase against the trigger is free, so timings carry a tolerance.
  task automatic near(input string what, input value_t exp, input value_t got, input int tol);
    total_checks++;
    if ((got >= exp - tol && got <= exp + tol) !== 1'b1)
    begin
      mismatches++;
      $display("CHECK FAILED %s expected %0d seen %0d", what, exp, got);
    end
  endtask
  task automatic trig(input value_t v);
    ch_u.set_trig(0, 32'h0000_0000);
    ch_u.set_trig(0, v);
  endtask
  task automatic measure(output int n);
    n = 0;
    while (running[0] === 1'b1 && n < 3200)
    begin
      @(negedge clk);
      n++;
    end
  endtask
  task automatic final_report;
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  initial
  begin
    for (int g = 0; g < NUM_GEN; g++)
    begin
      trig_mode[g] = (g == 1 || g == 2) ? TRIG_TIME : TRIG_OFF;
      loop_mode[g] = LOOP_OFF;
      loop_count[g] = 32'h0000_0000;
      loop_restart_section[g] = 7'h01;
      sect_count[g] = 7'h03;
      idle_value[g] = 32'hFFFF_FFFB;
      {month_mask[g], day_mask[g], wday_mask[g], hour_mask[g]} = '1;
      min_mask[g] = (g == 2) ? 60'h0 : '1;
      sec_mask[g] = (g == 1) ? 60'h8 : '1;
    end
    trig_mode[0] = TRIG_ONCE;
    repeat (16) @(negedge clk);
    srst = 1'b0;
    repeat (2) @(negedge clk);
    chk("idle out", 32'hFFFF_FFFB, out_value[0]);
    for (int g = 0; g < 3; g++)
      for (int s = 0; s < 3; s++)
      begin
        cfg_we = 1'b1;
        cfg_gen = 3'(g);
        cfg_sect = 7'(s);
        cfg_section = secs[s];
        @(negedge clk);
      end
    cfg_we = 1'b0;
    c = 0;
    while (running[1] !== 1'b1 && c < 2000)
    begin
      @(negedge clk);
      c++;
    end
    chk("time second", 32'h0000_0003, 32'(tod_sec));
    chk("empty field", 32'h0000_0000, 32'(running[2]));
    $display("test time done");
    foreach (rows[i])
    begin
      loop_mode[0] = rows[i].lm;
      loop_count[0] = rows[i].lc;
      ch_u.set_loop(0, rows[i].lv);
      trig(32'h0000_0005);
      repeat (2) @(negedge clk);
      measure(c);
      near("run cycles", value_t'(rows[i].ticks * TC), value_t'(c + 2), TC);
      chk("loop active", 32'(rows[i].lm == LOOP_INFINITE), 32'(running[0]));
      trig_mode[0] = TRIG_OFF;
      repeat (2) @(negedge clk);
      chk("stopped", 32'h0000_0000, 32'(running[0]));
      chk("idle out", 32'hFFFF_FFFB, out_value[0]);
      trig_mode[0] = TRIG_ONCE;
      $display("test loop row %0d done", i);
    end
    loop_mode[0] = LOOP_COUNTED;
    loop_count[0] = 32'h0000_0002;
    trig(32'h0000_0005);
    repeat (100) @(negedge clk);
    chk("const level", 32'h0000_0007, out_value[0]);
    repeat (500) @(negedge clk);
    near("first slope", 32'h0000_0039, out_value[0], 2);
    repeat (800) @(negedge clk);
    near("repeat slope", 32'h0000_004D, out_value[0], 2);
    measure(c);
    $display("test slope done");
    loop_mode[0] = LOOP_OFF;
    trig_mode[0] = TRIG_GATE;
    trig(32'h0000_0005);
    repeat (100) @(negedge clk);
    chk("gate run", 32'h0000_0001, 32'(running[0]));
    ch_u.set_trig(0, 32'hFFFF_FFFF);
    repeat (2) @(negedge clk);
    chk("gate stop", 32'h0000_0000, 32'(running[0]));
    chk("gate idle", 32'hFFFF_FFFB, out_value[0]);
    $display("test gate done");
    trig_mode[0] = TRIG_RETRIG;
    trig(32'h0000_0005);
    repeat (600) @(negedge clk);
    trig(32'h0000_0005);
    repeat (2) @(negedge clk);
    chk("restart level", 32'h0000_0007, out_value[0]);
    measure(c);
    near("restart length", value_t'(300 * TC), value_t'(c + 4), TC);
    $display("test retrigger done");
    trig_mode[0] = TRIG_ONCE;
    trig(32'h0000_0005);
    repeat (200) @(negedge clk);
    trig(32'h0000_0005);
    repeat (2) @(negedge clk);
    measure(c);
    near("single length", value_t'(300 * TC), value_t'(c + 204), 2 * TC);
    chk("other idle", 32'h0000_0000, 32'(running[3]));
    $display("test single edge done");
    trig_mode[4] = TRIG_ONCE;
    sect_count[4] = 7'h01;
    cfg_we = 1'b1;
    cfg_gen = 3'h4;
    cfg_sect = 7'h00;
    cfg_section = '{16'h0001, UNIT_MIN, SHAPE_CONST, 32'h0000_0011};
    @(negedge clk);
    cfg_we = 1'b0;
    ch_u.set_trig(4, 32'h0000_0005);
    loop_mode[0] = LOOP_COUNTED;
    loop_restart_section[0] = 7'h00;
    trig(32'h0000_0005);
    repeat (1220) @(negedge clk);
    near("const return", 32'h0000_001D, out_value[0], 2);
    repeat (80) @(negedge clk);
    chk("const settled", 32'h0000_0007, out_value[0]);
    measure(c);
    $display("test return done");
    sect_count[0] = 7'h00;
    trig(32'h0000_0005);
    repeat (2) @(negedge clk);
    chk("empty list", 32'h0000_0000, 32'(running[0]));
    chk("minute unit", 32'h0000_0001, 32'(running[4]));
    chk("minute level", 32'h0000_0011, out_value[4]);
    $display("test unit done");
    final_report();
  end
  initial
  begin
    repeat (40000) @(posedge clk);
    mismatches++;
    final_report();
  end
endmodule // tb

bind profile_bank profile_bank_checker chk_u (.clk, .srst, .trig_mode, .sect_count, .idle_value,
  .trig_value, .out_value, .running);

// ### rtl/profile_bank.sv
// Overview of operation
// - Up to 100 sections, each duration unit shape final.
// - Duration unit is second, minute or hour.
// - Constant holds level; slope ends at final value.
// - Slope on repeat ramps from previous final value.
// - Constant on repeat transits within 0.1 seconds.
// - Gate mode runs only while source above zero.
// - Single edge starts full run, ignoring later changes.
// - In retrigger mode every rising edge restarts from first section.
// - Idle value shown before and after generation.
// - Looping off, counted or infinite repeats.
// - Channel looping compares completed cycles to channel.
// - Repeats start at the loop restart section.
// - Time trigger when all date fields match.
// - Any empty time field prevents time starts.
// - Time start runs whole profile like single edge.
// - Eight independent generators, one output each.
// - Channel looping stops when cycles reach channel value.
module profile_bank #(
  parameter int unsigned TICK_CYCLES = profile_pkg::TICK_CYCLES_DEF
) (
  input  wire logic                    clk,
  input  wire logic                    srst,
  input  wire logic                    cfg_we,
  input  wire logic [2:0]              cfg_gen,
  input  wire profile_pkg::sect_idx_t  cfg_sect,
  input  wire profile_pkg::section_t   cfg_section,
  input  wire profile_pkg::trig_mode_t trig_mode [profile_pkg::NUM_GEN],
  input  wire profile_pkg::loop_mode_t loop_mode [profile_pkg::NUM_GEN],
  input  wire logic [31:0]             loop_count [profile_pkg::NUM_GEN],
  input  wire profile_pkg::sect_idx_t  loop_restart_section [profile_pkg::NUM_GEN],
  input  wire profile_pkg::sect_idx_t  sect_count [profile_pkg::NUM_GEN],
  input  wire profile_pkg::value_t     idle_value [profile_pkg::NUM_GEN],
  input  wire profile_pkg::value_t     trig_value [profile_pkg::NUM_GEN],
  input  wire profile_pkg::value_t     loop_value [profile_pkg::NUM_GEN],
  input  wire logic [12:0]             month_mask [profile_pkg::NUM_GEN],
  input  wire logic [31:0]             day_mask [profile_pkg::NUM_GEN],
  input  wire logic [6:0]              wday_mask [profile_pkg::NUM_GEN],
  input  wire logic [23:0]             hour_mask [profile_pkg::NUM_GEN],
  input  wire logic [59:0]             min_mask [profile_pkg::NUM_GEN],
  input  wire logic [59:0]             sec_mask [profile_pkg::NUM_GEN],
  input  wire logic [3:0]              tod_month,
  input  wire logic [4:0]              tod_day,
  input  wire logic [2:0]              tod_wday,
  input  wire logic [4:0]              tod_hour,
  input  wire logic [5:0]              tod_min,
  input  wire logic [5:0]              tod_sec,
  output profile_pkg::value_t          out_value [profile_pkg::NUM_GEN],
  output logic                         running [profile_pkg::NUM_GEN]
);
  import profile_pkg::*;

  tick_if tk ();

  tick_divider #(
    .TICK_CYCLES (TICK_CYCLES)
  ) u_tick (
    .clk  (clk),
    .srst (srst),
    .t    (tk.src)
  );

  section_t   sect_q [NUM_GEN][MAX_SECT];
  section_t   sect_d [NUM_GEN][MAX_SECT];
  logic [5:0] sec_prev_q;
  logic       new_sec;

  // Section table write; indices past the table are dropped.
  always_comb
  begin
    sect_d = sect_q;
    if (cfg_we && (cfg_sect < sect_idx_t'(MAX_SECT)))
      sect_d[cfg_gen][cfg_sect] = cfg_section;
  end

  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      for (int g = 0; g < NUM_GEN; g++)
        for (int s = 0; s < MAX_SECT; s++)
          sect_q[g][s] <= SECT_RESET;
      sec_prev_q <= SEC_RESET;
    end
    else
    begin
      sect_q     <= sect_d;
      sec_prev_q <= tod_sec;
    end
  end

  // One evaluation per new second gives one-second resolution without retriggering.
  assign new_sec = (tod_sec != sec_prev_q);

  for (genvar g = 0; g < NUM_GEN; g++)
  begin : gen_pg
    state_t    st_q;
    state_t    st_d;
    sect_idx_t idx_q;
    sect_idx_t idx_d;
    ticks_t    el_q;
    ticks_t    el_d;
    logic [31:0] cyc_q;
    logic [31:0] cyc_d;
    logic      rep_q;
    logic      rep_d;
    value_t    from_q;
    value_t    from_d;
    value_t    out_q;
    value_t    out_d;
    logic      pos_q;
    logic      pos;
    logic      rise;
    logic      tmatch;
    logic      start;
    logic      more;
    sect_idx_t cnt;
    section_t  cur;
    ticks_t    tot;

    assign pos = (trig_value[g] > 0);
    assign rise = pos && !pos_q;
    assign cnt = (sect_count[g] > sect_idx_t'(MAX_SECT)) ? sect_idx_t'(MAX_SECT) : sect_count[g];
    assign cur = sect_q[g][idx_q];
    assign tot = dur_ticks(cur.dur, cur.unit);

    // An empty mask can never hit, so one empty field blocks every time start.
    assign tmatch = new_sec
                  && mask_hit(64'(month_mask[g]), 6'(tod_month))
                  && mask_hit(64'(day_mask[g]), 6'(tod_day))
                  && mask_hit(64'(wday_mask[g]), 6'(tod_wday))
                  && mask_hit(64'(hour_mask[g]), 6'(tod_hour))
                  && mask_hit(64'(min_mask[g]), tod_min)
                  && mask_hit(64'(sec_mask[g]), tod_sec);

    always_comb
    begin
      case (loop_mode[g])
        LOOP_COUNTED:  more = (cyc_q + 32'h0000_0001) < loop_count[g];
        LOOP_CHANNEL:  more = signed'({1'b0, cyc_q + 32'h0000_0001})
                              < 33'(loop_value[g]);
        LOOP_INFINITE: more = 1'b1;
        default:       more = 1'b0;
      endcase
    end

    always_comb
    begin
      case (trig_mode[g])
        TRIG_GATE:   start = pos && (st_q == ST_IDLE);
        TRIG_ONCE:   start = rise && (st_q != ST_RUN);
        TRIG_RETRIG: start = rise;
        TRIG_TIME:   start = tmatch && (st_q != ST_RUN);
        default:     start = 1'b0;
      endcase
      start = start && (cnt != IDX_RESET);
    end

    always_comb
    begin
      st_d   = st_q;
      idx_d  = idx_q;
      el_d   = el_q;
      cyc_d  = cyc_q;
      rep_d  = rep_q;
      from_d = from_q;
      if (start)
      begin
        st_d   = ST_RUN;
        idx_d  = IDX_RESET;
        el_d   = TICKS_RESET;
        cyc_d  = 32'h0000_0000;
        rep_d  = 1'b0;
        from_d = idle_value[g];
      end
      else
      begin
        case (st_q)
          ST_RUN:
          begin
            if (trig_mode[g] == TRIG_OFF || (trig_mode[g] == TRIG_GATE && !pos))
              st_d = ST_IDLE;
            else if (tk.tick)
            begin
              if (el_q + 40'h00_0000_0001 < tot)
                el_d = el_q + 40'h00_0000_0001;
              else
              begin
                from_d = cur.final_value;
                el_d   = TICKS_RESET;
                rep_d  = 1'b0;
                if (idx_q + 7'h01 < cnt)
                  idx_d = idx_q + 7'h01;
                else if (more && loop_restart_section[g] < cnt)
                begin
                  cyc_d = cyc_q + 32'h0000_0001;
                  idx_d = loop_restart_section[g];
                  rep_d = 1'b1;
                end
                else
                begin
                  cyc_d = cyc_q + 32'h0000_0001;
                  st_d  = ST_DONE;
                end
              end
            end
          end
          ST_DONE:
          begin
            // A gate must fall before the level can start another run.
            if (trig_mode[g] != TRIG_GATE || !pos)
              st_d = ST_IDLE;
            if (trig_mode[g] != TRIG_GATE)
              st_d = ST_DONE;
          end
          default:
            st_d = ST_IDLE;
        endcase
      end
    end

    always_comb
    begin
      if (st_q != ST_RUN)
        out_d = idle_value[g];
      else if (cur.shape == SHAPE_SLOPE)
        out_d = lerp(from_q, cur.final_value, el_q, tot);
      else if (rep_q && el_q < ticks_t'(TRANS_TICKS))
        out_d = lerp(from_q, cur.final_value, el_q, ticks_t'(TRANS_TICKS));
      else
        out_d = cur.final_value;
    end

    always_ff @(posedge clk)
    begin
      if (srst)
      begin
        st_q   <= STATE_RESET;
        idx_q  <= IDX_RESET;
        el_q   <= TICKS_RESET;
        cyc_q  <= 32'h0000_0000;
        rep_q  <= 1'b0;
        from_q <= 32'sh0000_0000;
        out_q  <= 32'sh0000_0000;
        pos_q  <= 1'b0;
      end
      else
      begin
        st_q   <= st_d;
        idx_q  <= idx_d;
        el_q   <= el_d;
        cyc_q  <= cyc_d;
        rep_q  <= rep_d;
        from_q <= from_d;
        out_q  <= out_d;
        pos_q  <= pos;
      end
    end

    assign out_value[g] = out_q;
    assign running[g]   = (st_q == ST_RUN);
  end

endmodule // profile_bank

// ### rtl/profile_pkg.sv
package profile_pkg;

  localparam int NUM_GEN         = 8;
  localparam int MAX_SECT        = 100;
  localparam int CLK_FREQ_HZ     = 200_000_000;
  localparam int TICK_TIME_MS    = 10;
  localparam int TICK_CYCLES_DEF = CLK_FREQ_HZ / 1000 * TICK_TIME_MS;
  localparam int TRANS_TIME_MS   = 100;
  localparam int TRANS_TICKS     = TRANS_TIME_MS / TICK_TIME_MS;
  localparam int TICKS_PER_SEC   = 1000 / TICK_TIME_MS;
  localparam int TICKS_PER_MIN   = TICKS_PER_SEC * 60;
  localparam int TICKS_PER_HOUR  = TICKS_PER_SEC * 3600;

  typedef logic signed [31:0] value_t;
  typedef logic [6:0]         sect_idx_t;
  typedef logic [39:0]        ticks_t;

  typedef enum logic [1:0] {UNIT_SEC = 2'h0, UNIT_MIN = 2'h1, UNIT_HOUR = 2'h2} unit_t;
  typedef enum logic {SHAPE_CONST = 1'b0, SHAPE_SLOPE = 1'b1} shape_t;
  typedef enum logic [2:0] {
    TRIG_OFF = 3'h0, TRIG_GATE = 3'h1, TRIG_ONCE = 3'h2, TRIG_RETRIG = 3'h3, TRIG_TIME = 3'h4
  } trig_mode_t;
  typedef enum logic [1:0] {
    LOOP_OFF = 2'h0, LOOP_COUNTED = 2'h1, LOOP_CHANNEL = 2'h2, LOOP_INFINITE = 2'h3
  } loop_mode_t;
  typedef enum logic [2:0] {ST_IDLE = 3'b001, ST_RUN = 3'b010, ST_DONE = 3'b100} state_t;

  typedef struct packed {
    logic [15:0] dur;
    unit_t       unit;
    shape_t      shape;
    value_t      final_value;
  } section_t;

  localparam section_t   SECT_RESET  = '0;
  localparam state_t     STATE_RESET = ST_IDLE;
  localparam sect_idx_t  IDX_RESET   = 7'h00;
  localparam ticks_t     TICKS_RESET = 40'h00_0000_0000;
  localparam logic [5:0] SEC_RESET   = 6'h00;

  function automatic ticks_t dur_ticks(input logic [15:0] dur, input unit_t unit);
    ticks_t scale;
    case (unit)
      UNIT_MIN:  scale = ticks_t'(TICKS_PER_MIN);
      UNIT_HOUR: scale = ticks_t'(TICKS_PER_HOUR);
      default:   scale = ticks_t'(TICKS_PER_SEC);
    endcase
    return ticks_t'({24'h00_0000, dur} * scale);
  endfunction

  // Linear blend from a to b; a zero span returns b at once.
  function automatic value_t lerp(input value_t a, input value_t b, input ticks_t el,
                                  input ticks_t tot);
    logic signed [79:0] d;
    logic signed [79:0] e;
    logic signed [79:0] t;
    logic signed [79:0] p;
    d = 80'(b) - 80'(a);
    e = signed'({40'h00_0000_0000, el});
    t = signed'({40'h00_0000_0000, tot});
    if (tot == '0)
      p = 80'(b);
    else
      p = 80'(a) + (d * e) / t;
    return value_t'(p[31:0]);
  endfunction

  function automatic logic mask_hit(input logic [63:0] mask, input logic [5:0] idx);
    return mask[idx];
  endfunction

endpackage

// ### rtl/tick_divider.sv
module tick_divider #(
  parameter int unsigned TICK_CYCLES = profile_pkg::TICK_CYCLES_DEF
) (
  input wire logic clk,
  input wire logic srst,
  tick_if.src      t
);
  import profile_pkg::*;

  logic [31:0] cnt_q;
  logic [31:0] cnt_d;
  logic        tick_q;
  logic        tick_d;

  always_comb
  begin
    tick_d = 1'b0;
    cnt_d  = cnt_q + 32'h0000_0001;
    if (cnt_q >= 32'(TICK_CYCLES - 1))
    begin
      cnt_d  = 32'h0000_0000;
      tick_d = 1'b1;
    end
  end

  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      cnt_q  <= 32'h0000_0000;
      tick_q <= 1'b0;
    end
    else
    begin
      cnt_q  <= cnt_d;
      tick_q <= tick_d;
    end
  end

  assign t.tick = tick_q;

endmodule // tick_divider

// ### rtl/tick_if.sv
interface tick_if;
  logic tick;
  modport src (output tick);
  modport snk (input tick);
endinterface
